// *** design/srx_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module srx_top
  import srx_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          rstn,
  input  wire logic [7:0]    bus_addr,
  input  wire logic [7:0]    bus_wdata,
  input  wire logic          bus_wr,
  input  wire logic          bus_rd,
  output logic      [7:0]    bus_rdata,
  input  wire logic          rx_char_done,
  input  wire logic [7:0]    rx_char_data,
  input  wire logic          rx_char_ninth,
  input  wire logic          nine_bit_mode,
  input  wire logic          rx_noise_det,
  input  wire logic          rx_frame_det,
  input  wire logic          rx_parity_det,
  input  wire logic          rx_break_det,
  input  wire logic          rx_line_high,
  input  wire logic          rx_start_low,
  input  wire logic          rx_false_start,
  input  wire logic          rx_idle_char,
  output logic      [7:0]    transmit_byte,
  output logic               tx_load,
  output logic               sample_tick,
  output logic               baud_tick,
  output logic               err_irq,
  output logic               irq
);

  //////////////////////////////////////////////////////////////////
  // Decode and event terms.
  //////////////////////////////////////////////////////////////////
  logic [7:0]          received_byte;
  logic                rx_ninth_bit;
  logic                full_reg;
  logic                arm_full_reg;
  logic [SRX_NERR-1:0] err_reg;
  logic [SRX_NERR-1:0] arm_err_reg;
  logic [SRX_NERR-1:0] err_set;
  logic                brk_reg;
  logic                arm_brk_reg;
  logic                brk_block_reg;
  logic                rpf_reg;
  logic [3:0]          en_reg;
  logic [1:0]          pre_reg;
  logic [2:0]          bd_reg;
  logic [5:0]          istat_reg;
  logic [5:0]          imask_reg;
  logic [5:0]          irq_ev;
  logic [5:0]          pre_cnt_reg;
  logic [6:0]          bd_cnt_reg;
  logic [3:0]          os_cnt_reg;
  logic [5:0]          pre_last;
  logic [6:0]          bd_last;
  logic                pre_wrap;
  logic                bd_wrap;
  logic                rd_st1;
  logic                rd_st2;
  logic                rd_data;
  logic                wr_sel;
  logic                accept;
  logic                ovr_evt;
  logic                brk_set;
  logic                full_set;

  // Strobe decodes.
  assign rd_st1  = bus_rd && (bus_addr == SRX_OFS_STAT1);
  assign rd_st2  = bus_rd && (bus_addr == SRX_OFS_STAT2);
  assign rd_data = bus_rd && (bus_addr == SRX_OFS_DATA);
  assign wr_sel  = bus_wr && (bus_addr == SRX_OFS_DATA);

  assign accept  = rx_char_done && !full_reg;
  assign ovr_evt = rx_char_done && full_reg;
  assign brk_set = rx_break_det && !brk_block_reg;
  assign full_set = accept || rx_break_det;

  // Error set sources in status-one bit order.
  always_comb begin
    err_set           = '0;
    err_set[SRX_E_OVR] = ovr_evt;
    err_set[SRX_E_NF]  = rx_noise_det;
    err_set[SRX_E_FE]  = rx_frame_det || rx_break_det;
    err_set[SRX_E_PE]  = rx_parity_det;
  end

  //////////////////////////////////////////////////////////////////
  // Data buffer and ninth bit; reset leaves them alone.
  //////////////////////////////////////////////////////////////////
  // buffer without reset
  always_ff @(posedge ref_clk) begin
    if (accept) begin
      received_byte <= rx_char_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rx_break_det && nine_bit_mode) begin
      rx_ninth_bit <= 1'b0;
    end else if (accept) begin
      rx_ninth_bit <= nine_bit_mode ? rx_char_ninth : rx_char_data[7];
    end
  end

  //////////////////////////////////////////////////////////////////
  // Receive flags and their clearing sequences.
  //////////////////////////////////////////////////////////////////
  // full flag, set wins over clear
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      full_reg <= 1'b0;
    end else if (full_set) begin
      full_reg <= 1'b1;
    end else if (rd_data && arm_full_reg) begin
      full_reg <= 1'b0;
    end
  end

  // Arms the full flag clear when status one is seen with it set.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      arm_full_reg <= 1'b0;
    end else if (rd_st1) begin
      arm_full_reg <= full_reg;
    end else if (rd_data) begin
      arm_full_reg <= 1'b0;
    end
  end

  // One flag and one arm per error; the arm remembers a status read.
  genvar gi;
  generate
    for (gi = 0; gi < SRX_NERR; gi++) begin : g_err
      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          err_reg[gi] <= 1'b0;
        end else if (err_set[gi]) begin
          err_reg[gi] <= 1'b1;
        end else if (rd_data && arm_err_reg[gi]) begin
          err_reg[gi] <= 1'b0;
        end
      end

      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          arm_err_reg[gi] <= 1'b0;
        end else if (rd_st1) begin
          arm_err_reg[gi] <= err_reg[gi];
        end else if (rd_data) begin
          arm_err_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // break flag and its status-two arm
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      brk_reg <= 1'b0;
    end else if (brk_set) begin
      brk_reg <= 1'b1;
    end else if (rd_data && arm_brk_reg) begin
      brk_reg <= 1'b0;
    end
  end

  // Arms the break clear on a status-two read with the flag set.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      arm_brk_reg <= 1'b0;
    end else if (rd_st2) begin
      arm_brk_reg <= brk_reg;
    end else if (rd_data) begin
      arm_brk_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      brk_block_reg <= 1'b0;
    end else if (rx_break_det) begin
      brk_block_reg <= 1'b1;
    end else if (rx_line_high) begin
      brk_block_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rpf_reg <= 1'b0;
    end else if (rx_start_low) begin
      rpf_reg <= 1'b1;
    end else if (rx_false_start || rx_idle_char) begin
      rpf_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////
  // Control, rate, interrupt registers and transmit byte.
  //////////////////////////////////////////////////////////////////
  // Enable bits and rate fields.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      en_reg  <= SRX_RST_EN;
      pre_reg <= SRX_RST_RATE[SRX_RT_PRE +: 2];
      bd_reg  <= SRX_RST_RATE[SRX_RT_BD +: 3];
    end else if (bus_wr && bus_addr == SRX_OFS_CTRL3) begin
      en_reg <= bus_wdata[3:0];
    end else if (bus_wr && bus_addr == SRX_OFS_RATE) begin
      pre_reg <= bus_wdata[SRX_RT_PRE +: 2];
      bd_reg  <= bus_wdata[SRX_RT_BD +: 3];
    end
  end

  // Sticky events, write one to clear; a new event wins.
  assign irq_ev = {brk_set, full_set, err_set};
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      istat_reg <= SRX_RST_IRQ;
    end else if (bus_wr && bus_addr == SRX_OFS_ISTAT) begin
      istat_reg <= (istat_reg & ~bus_wdata[5:0]) | irq_ev;
    end else begin
      istat_reg <= istat_reg | irq_ev;
    end
  end

  // Interrupt mask.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      imask_reg <= SRX_RST_IRQ;
    end else if (bus_wr && bus_addr == SRX_OFS_IMASK) begin
      imask_reg <= bus_wdata[5:0];
    end
  end

  assign err_irq = |(err_reg & en_reg);
  assign irq     = |(istat_reg & imask_reg);

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      transmit_byte <= 8'h00;
      tx_load       <= 1'b0;
    end else begin
      tx_load <= wr_sel;
      if (wr_sel) begin
        transmit_byte <= bus_wdata;
      end
    end
  end

  // Read data, registered one cycle after the strobe.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      bus_rdata <= 8'h00;
    end else if (bus_rd) begin
      case (bus_addr)
        SRX_OFS_DATA:  bus_rdata <= received_byte;
        SRX_OFS_STAT1: bus_rdata <= {2'h0, full_reg, 1'b0, err_reg};
        SRX_OFS_STAT2: bus_rdata <= {6'h00, brk_reg, rpf_reg};
        SRX_OFS_CTRL3: bus_rdata <= {rx_ninth_bit, 3'h0, en_reg};
        SRX_OFS_RATE:  bus_rdata <= {2'h0, pre_reg, 1'b0, bd_reg};
        SRX_OFS_ISTAT: bus_rdata <= {2'h0, istat_reg};
        SRX_OFS_IMASK: bus_rdata <= {2'h0, imask_reg};
        default:       bus_rdata <= 8'h00;
      endcase
    end else begin
      bus_rdata <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////
  // Rate generator shared by receiver and transmitter.
  //////////////////////////////////////////////////////////////////
  // prescale divisor
  assign pre_last = 6'(SRX_PRE_BASE * srx_pd(pre_reg) - 6'h01);
  assign bd_last  = 7'(srx_bd(bd_reg) - 8'h01);
  assign pre_wrap = (pre_cnt_reg == pre_last);
  assign bd_wrap  = pre_wrap && (bd_cnt_reg == bd_last);

  // 64 x PD x BD clocks
  always_ff @(posedge ref_clk) begin
    if (!rstn || (bus_wr && bus_addr == SRX_OFS_RATE)) begin
      pre_cnt_reg <= 6'h00;
      bd_cnt_reg  <= 7'h00;
      os_cnt_reg  <= 4'h0;
    end else begin
      pre_cnt_reg <= pre_wrap ? 6'h00 : pre_cnt_reg + 6'h01;
      if (pre_wrap) begin
        bd_cnt_reg <= bd_wrap ? 7'h00 : bd_cnt_reg + 7'h01;
      end
      if (bd_wrap) begin
        os_cnt_reg <= os_cnt_reg + 4'h1;
      end
    end
  end

  // Registered tick outputs.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sample_tick <= 1'b0;
      baud_tick   <= 1'b0;
    end else begin
      sample_tick <= bd_wrap;
      baud_tick   <= bd_wrap && (os_cnt_reg == SRX_OS_LAST);
    end
  end

  //////////////////////////////////////////////////////////////////
  // Checks.
  //////////////////////////////////////////////////////////////////
  sequence s_st1_seen_ovr;
    rd_st1 && err_reg[SRX_E_OVR];
  endsequence

  sequence s_data_rd_quiet;
    rd_data && !rx_char_done;
  endsequence

  property p_ovr_keep;
    @(posedge ref_clk) disable iff (!rstn)
      ovr_evt |=> err_reg[SRX_E_OVR] && received_byte == $past(received_byte);
  endproperty
  a_ovr_keep: assert property (p_ovr_keep) else $error("overrun lost buffer");

  property p_ovr_clear;
    @(posedge ref_clk) disable iff (!rstn)
      s_st1_seen_ovr ##1 !rd_data ##1 s_data_rd_quiet
      |=> !err_reg[SRX_E_OVR];
  endproperty
  a_ovr_clear: assert property (p_ovr_clear) else $error("overrun not cleared");

  property p_ovr_hold;
    @(posedge ref_clk) disable iff (!rstn)
      rd_data && !arm_err_reg[SRX_E_OVR] && err_reg[SRX_E_OVR] |=> err_reg[SRX_E_OVR];
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("overrun cleared early");

  property p_err_irq;
    @(posedge ref_clk) disable iff (!rstn)
      err_irq == |(err_reg & en_reg);
  endproperty
  a_err_irq: assert property (p_err_irq) else $error("error irq mismatch");

  property p_break;
    @(posedge ref_clk) disable iff (!rstn)
      brk_set |=> brk_reg && full_reg && err_reg[SRX_E_FE];
  endproperty
  a_break: assert property (p_break) else $error("break flags missing");

  property p_brk_rearm;
    @(posedge ref_clk) disable iff (!rstn)
      rx_break_det ##1 (!rx_line_high)[*2] |-> !brk_set;
  endproperty
  a_brk_rearm: assert property (p_brk_rearm) else $error("break rearmed");

  property p_rpf;
    @(posedge ref_clk) disable iff (!rstn)
      rx_false_start && !rx_start_low |=> !rpf_reg;
  endproperty
  a_rpf: assert property (p_rpf) else $error("progress flag stuck");

  // A rate write restarts the divider, so the window must be free of one.
  sequence s_rate_quiet;
    !(bus_wr && bus_addr == SRX_OFS_RATE);
  endsequence

  sequence s_fast_tick;
    pre_reg == 2'h1 && bd_reg == 3'h0 && sample_tick && $stable(pre_reg) && s_rate_quiet;
  endsequence

  property p_tick;
    @(posedge ref_clk) disable iff (!rstn)
      s_fast_tick ##1 s_rate_quiet[*6] ##1 s_rate_quiet[*5] |=> sample_tick;
  endproperty
  a_tick: assert property (p_tick) else $error("sample period wrong");

endmodule : srx_top
`default_nettype wire

// *** inc/srx_pkg.sv ***
// Overview of operation
// - Char done while full sets overrun; new char dropped, buffer kept.
// - Overrun clears by status-one read with flag set, then buffer read.
// - Overrun requests error interrupt only when its enable is set.
// - Noise sets noise flag; enable gates irq; sequence or reset clears.
// - Low stop bit sets framing flag; enable gates irq; sequence clears.
// - Parity mismatch sets parity flag; enable gates irq; sequence clears.
// - Break sets break, framing and full flags; clears ninth bit in 9-bit.
// - Break interrupts through irq when mask bit 5 is set; status-two then buffer read clears; rearm needs high.
// - Low at first sample slot sets in-progress; false start or idle clears.
// - Buffer read gives received byte, write gives transmit byte; reset keeps the received byte, clears the transmit byte.
// - One rate setting drives both receiver and transmitter.
// - Prescale field codes 0..3 divide by 1, 3, 4, 13; reset 0.
// - Rate field divides by two to the code, 1 to 128; reset 0.
// - Bit rate is clock over 64 times prescale times rate divisor.
// - Moving a char into the buffer sets full; sequence read clears.
`default_nettype none
package srx_pkg;
  localparam int unsigned SRX_AW = 8;
  localparam int unsigned SRX_DW = 8;
  // Register offsets.
  localparam logic [7:0] SRX_OFS_CTRL3 = 8'h15;
  localparam logic [7:0] SRX_OFS_STAT1 = 8'h16;
  localparam logic [7:0] SRX_OFS_STAT2 = 8'h17;
  localparam logic [7:0] SRX_OFS_DATA  = 8'h18;
  localparam logic [7:0] SRX_OFS_RATE  = 8'h19;
  localparam logic [7:0] SRX_OFS_ISTAT = 8'h1A;
  localparam logic [7:0] SRX_OFS_IMASK = 8'h1B;
  // Status one: full at bit 5, errors overrun, noise, framing, parity at 3..0.
  localparam int unsigned SRX_ST1_FULL = 5;
  localparam int unsigned SRX_E_OVR    = 3;
  localparam int unsigned SRX_E_NF     = 2;
  localparam int unsigned SRX_E_FE     = 1;
  localparam int unsigned SRX_E_PE     = 0;
  localparam int unsigned SRX_NERR     = 4;
  // Status two fields.
  localparam int unsigned SRX_ST2_BRK = 1;
  localparam int unsigned SRX_ST2_RPF = 0;
  // Control three: ninth bit at 7, enables in the error bit order.
  localparam int unsigned SRX_C3_RX9 = 7;
  // Rate register fields.
  localparam int unsigned SRX_RT_PRE = 4;
  localparam int unsigned SRX_RT_BD  = 0;
  // Interrupt status layout: errors 3..0, full 4, break 5.
  localparam int unsigned SRX_I_FULL = 4;
  localparam int unsigned SRX_I_BRK  = 5;
  localparam int unsigned SRX_NIRQ   = 6;
  // Reset values.
  localparam logic [7:0] SRX_RST_RATE  = 8'h00;
  localparam logic [3:0] SRX_RST_EN    = 4'h0;
  localparam logic [5:0] SRX_RST_IRQ   = 6'h00;
  // Timing: 64 clocks per bit at unit divisors, sampled 16 times per bit.
  localparam int unsigned SRX_RATE_BASE = 64;
  localparam int unsigned SRX_OVERSMP   = 16;
  localparam logic [5:0]  SRX_PRE_BASE  = 6'(SRX_RATE_BASE / SRX_OVERSMP);
  localparam logic [3:0]  SRX_OS_LAST   = 4'(SRX_OVERSMP - 1);

  // Prescale divisor for a field code.
  function automatic logic [5:0] srx_pd(input logic [1:0] code);
    case (code)
      2'h0:    srx_pd = 6'h01;
      2'h1:    srx_pd = 6'h03;
      2'h2:    srx_pd = 6'h04;
      default: srx_pd = 6'h0D;
    endcase
  endfunction : srx_pd

  // Rate divisor for a field code.
  function automatic logic [7:0] srx_bd(input logic [2:0] code);
    srx_bd = 8'h01 << code;
  endfunction : srx_bd
endpackage : srx_pkg
`default_nettype wire

// *** verif/serial_rx_status_and_baud_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module serial_rx_status_and_baud_tb_top;
  import srx_pkg::*;
  typedef struct packed {
    logic [3:0] c;
    logic [7:0] s1;
    logic [7:0] s2;
    logic       e;
  } srx_row_type;
  // Event code, status one, status two and error request expected per row.
  localparam srx_row_type ROWS [9] = '{
    '{4'h0, 8'h20, 8'h00, 1'b0}, '{4'h1, 8'h04, 8'h00, 1'b1},
    '{4'h2, 8'h02, 8'h00, 1'b1}, '{4'h3, 8'h01, 8'h00, 1'b1},
    '{4'h4, 8'h22, 8'h02, 1'b1}, '{4'h5, 8'h00, 8'h01, 1'b0},
    '{4'h6, 8'h00, 8'h00, 1'b0}, '{4'h5, 8'h00, 8'h01, 1'b0},
    '{4'h7, 8'h00, 8'h00, 1'b0}};
  localparam int PDS [4] = '{1, 3, 4, 13};
  logic       ref_clk = 1'b0;
  logic       rstn, bus_wr, bus_rd, nine_bit_mode, ev_go, ev_ninth;
  logic [7:0] bus_addr, bus_wdata, bus_rdata, ev_data, transmit_byte;
  logic [3:0] ev_code;
  logic       rx_char_done, rx_char_ninth, rx_noise_det, rx_frame_det, rx_parity_det;
  logic       rx_break_det, rx_line_high, rx_start_low, rx_false_start, rx_idle_char;
  logic [7:0] rx_char_data;
  logic       tx_load, sample_tick, baud_tick, err_irq, irq;
  int         miscompares = 0;
  int         comparisons = 0;

  //////////////////////////////////////////////////////////////////////////////
  // The clock toggles every half period of 50 ns.
  always #50 ref_clk = ~ref_clk;

  srx_top i_dut (
    .ref_clk(ref_clk), .rstn(rstn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .rx_char_done(rx_char_done), .rx_char_data(rx_char_data),
    .rx_char_ninth(rx_char_ninth), .nine_bit_mode(nine_bit_mode),
    .rx_noise_det(rx_noise_det), .rx_frame_det(rx_frame_det),
    .rx_parity_det(rx_parity_det), .rx_break_det(rx_break_det),
    .rx_line_high(rx_line_high), .rx_start_low(rx_start_low),
    .rx_false_start(rx_false_start), .rx_idle_char(rx_idle_char),
    .transmit_byte(transmit_byte), .tx_load(tx_load), .sample_tick(sample_tick),
    .baud_tick(baud_tick), .err_irq(err_irq), .irq(irq));

  srx_remote_model i_remote (
    .ref_clk(ref_clk), .ev_go(ev_go), .ev_code(ev_code), .ev_data(ev_data),
    .ev_ninth(ev_ninth), .rx_char_done(rx_char_done), .rx_char_data(rx_char_data),
    .rx_char_ninth(rx_char_ninth), .rx_noise_det(rx_noise_det),
    .rx_frame_det(rx_frame_det), .rx_parity_det(rx_parity_det),
    .rx_break_det(rx_break_det), .rx_line_high(rx_line_high),
    .rx_start_low(rx_start_low), .rx_false_start(rx_false_start),
    .rx_idle_char(rx_idle_char));

  //////////////////////////////////////////////////////////////////////////////
  // Prints the verdict and ends the run.
  task automatic final_report();
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  // One write cycle on the register port.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask : wr

  // One read cycle; the data are taken in the following cycle only.
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    @(negedge ref_clk);
    chk(nm, {24'h0, e}, {24'h0, bus_rdata});
  endtask : rchk

  // Asks the far side for one event and lets it land in the flags.
  task automatic ev(input logic [3:0] c, input logic [7:0] d, input logic n);
    @(posedge ref_clk);
    ev_go <= 1'b1;
    ev_code <= c;
    ev_data <= d;
    ev_ninth <= n;
    @(posedge ref_clk);
    ev_go <= 1'b0;
    @(posedge ref_clk);
  endtask : ev

  // Full clearing sequence; the buffer is only read, never modified in place.
  task automatic clr(input logic [7:0] s1, input logic [7:0] s2, input logic [7:0] d);
    rchk("st1", SRX_OFS_STAT1, s1);
    rchk("st2", SRX_OFS_STAT2, s2);
    rchk("data", SRX_OFS_DATA, d);
  endtask : clr

  // Measures one bit period in clocks and the sample ticks inside it.
  task automatic rate_chk(input logic [1:0] p, input logic [2:0] b, input int pd);
    int n;
    int s;
    wr(SRX_OFS_RATE, {2'b00, p, 1'b0, b});
    for (int k = 0; k < 2; k++) begin
      n = 0;
      s = 0;
      do begin
        @(negedge ref_clk);
        n++;
        s += int'(sample_tick === 1'b1);
        if (n > 20000) begin
          miscompares++;
          final_report();
        end
      end while (baud_tick !== 1'b1);
    end
    chk("bit_period", 64 * pd * (1 << b), n);
    chk("samples", 16, s);
  endtask : rate_chk

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, table rows, then the awkward cases.
  initial begin
    rstn = 1'b0;
    {bus_wr, bus_rd, nine_bit_mode, ev_go, ev_ninth} = 5'h00;
    {bus_addr, bus_wdata, ev_data} = 24'h0;
    ev_code = 4'h0;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    rchk("rate", SRX_OFS_RATE, 8'h00);
    rchk("st1", SRX_OFS_STAT1, 8'h00);
    rchk("st2", SRX_OFS_STAT2, 8'h00);
    rchk("unmapped", 8'h00, 8'h00);
    wr(SRX_OFS_CTRL3, 8'h0F);
    for (int i = 0; i < 9; i++) begin
      ev(ROWS[i].c, 8'h30 + 8'(i), 1'b0);
      rchk("st1", SRX_OFS_STAT1, ROWS[i].s1);
      rchk("st2", SRX_OFS_STAT2, ROWS[i].s2);
      chk("err_irq", {31'h0, ROWS[i].e}, {31'h0, err_irq});
      clr(ROWS[i].s1, ROWS[i].s2, 8'h30);
      rchk("st1", SRX_OFS_STAT1, 8'h00);
    end
    // Break stays blocked until the line returns high.
    ev(4'h4, 8'h00, 1'b0);
    rchk("st2", SRX_OFS_STAT2, 8'h00);
    rchk("st1", SRX_OFS_STAT1, 8'h22);
    clr(8'h22, 8'h00, 8'h30);
    ev(4'h8, 8'h00, 1'b0);
    ev(4'h4, 8'h00, 1'b0);
    rchk("st2", SRX_OFS_STAT2, 8'h02);
    clr(8'h22, 8'h02, 8'h30);
    // Overrun caught by a late clearing sequence.
    wr(SRX_OFS_CTRL3, 8'h07);
    ev(4'h0, 8'hA1, 1'b0);
    rchk("st1", SRX_OFS_STAT1, 8'h20);
    ev(4'h0, 8'hB2, 1'b0);
    @(negedge ref_clk);
    chk("err_irq", 0, {31'h0, err_irq});
    rchk("data", SRX_OFS_DATA, 8'hA1);
    rchk("st1", SRX_OFS_STAT1, 8'h08);
    wr(SRX_OFS_CTRL3, 8'h0F);
    @(negedge ref_clk);
    chk("err_irq", 1, {31'h0, err_irq});
    ev(4'h0, 8'hC3, 1'b0);
    rchk("st1", SRX_OFS_STAT1, 8'h28);
    rchk("data", SRX_OFS_DATA, 8'hC3);
    rchk("st1", SRX_OFS_STAT1, 8'h00);
    // Ninth bit captured, then wiped by a break in nine-bit mode.
    nine_bit_mode <= 1'b1;
    ev(4'h0, 8'h11, 1'b1);
    rchk("ctrl3", SRX_OFS_CTRL3, 8'h8F);
    ev(4'h8, 8'h00, 1'b0);
    ev(4'h4, 8'h00, 1'b0);
    rchk("ctrl3", SRX_OFS_CTRL3, 8'h0F);
    clr(8'h22, 8'h02, 8'h11);
    // Sticky status, mask and write-one-to-clear of the interrupt.
    wr(SRX_OFS_ISTAT, 8'h3F);
    wr(SRX_OFS_IMASK, 8'h10);
    ev(4'h0, 8'h44, 1'b0);
    @(negedge ref_clk);
    chk("irq", 1, {31'h0, irq});
    rchk("istat", SRX_OFS_ISTAT, 8'h10);
    wr(SRX_OFS_IMASK, 8'h00);
    @(negedge ref_clk);
    chk("irq", 0, {31'h0, irq});
    wr(SRX_OFS_IMASK, 8'h10);
    wr(SRX_OFS_ISTAT, 8'h10);
    @(negedge ref_clk);
    chk("irq", 0, {31'h0, irq});
    // Transmit byte goes out, received byte still reads back.
    wr(SRX_OFS_DATA, 8'h5A);
    @(negedge ref_clk);
    chk("tx_load", 1, {31'h0, tx_load});
    chk("tx_byte", 8'h5A, {24'h0, transmit_byte});
    rchk("data", SRX_OFS_DATA, 8'h44);
    // Every prescale code, then every rate code.
    for (int p = 0; p < 4; p++) begin
      rate_chk(2'(p), 3'h0, PDS[p]);
    end
    for (int b = 1; b < 8; b++) begin
      rate_chk(2'h0, 3'(b), 1);
    end
    wr(SRX_OFS_RATE, 8'hFF);
    rchk("rate", SRX_OFS_RATE, 8'h37);
    // Mid-run reset clears the rate but keeps the buffer.
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    rchk("rate", SRX_OFS_RATE, 8'h00);
    rchk("st1", SRX_OFS_STAT1, 8'h00);
    rchk("data", SRX_OFS_DATA, 8'h44);
    final_report();
  end
endmodule : serial_rx_status_and_baud_tb_top
`default_nettype wire

// *** verif/srx_remote_model.sv ***
`timescale 1ns/1ns
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Far-side receiver front end: turns bench commands into one-cycle events.
module srx_remote_model (
  input  wire logic       ref_clk,
  input  wire logic       ev_go,
  input  wire logic [3:0] ev_code,
  input  wire logic [7:0] ev_data,
  input  wire logic       ev_ninth,
  output logic            rx_char_done,
  output logic      [7:0] rx_char_data,
  output logic            rx_char_ninth,
  output logic            rx_noise_det,
  output logic            rx_frame_det,
  output logic            rx_parity_det,
  output logic            rx_break_det,
  output logic            rx_line_high,
  output logic            rx_start_low,
  output logic            rx_false_start,
  output logic            rx_idle_char
);
  logic ch;

  assign ch = ev_go && ev_code == 4'h0;

  // Lines start idle so the device sees no event before the first command.
  initial begin
    {rx_char_done, rx_noise_det, rx_frame_det, rx_parity_det} = 4'h0;
    {rx_break_det, rx_line_high, rx_start_low, rx_false_start, rx_idle_char} = 5'h00;
    rx_char_data = 8'h00;
    rx_char_ninth = 1'b0;
  end

  // one pulse each
  // Released data lines flip to their inverse every clock, so a stale byte never holds steady.
  always @(posedge ref_clk) begin
    rx_char_done   <= ch;
    rx_noise_det   <= ev_go && ev_code == 4'h1;
    rx_frame_det   <= ev_go && ev_code == 4'h2;
    rx_parity_det  <= ev_go && ev_code == 4'h3;
    rx_break_det   <= ev_go && ev_code == 4'h4;
    rx_start_low   <= ev_go && ev_code == 4'h5;
    rx_false_start <= ev_go && ev_code == 4'h6;
    rx_idle_char   <= ev_go && ev_code == 4'h7;
    rx_line_high   <= ev_go && ev_code == 4'h8;
    rx_char_data   <= ch ? ev_data : ~rx_char_data;
    rx_char_ninth  <= ch ? ev_ninth : ~rx_char_ninth;
  end
endmodule : srx_remote_model
`default_nettype wire
